// >>> core/pcmh_highway_port.sv
// pcmh_highway_port: two-port pcm highway side of a four channel codec
// assumes: bit clock and frame sync come from the highway, core runs at 50 MHz,
// slot and sample settings are static inputs from the surrounding core logic
// Operation
// - frame start delay up to seven clocks, per direction
// - detect bit clock rate without programming
// - bit clock times all data on both ports
// - transmit drives only in slot, rising edge
// - receive sampled only in slot, falling edge
// - slot strobe pulls low while transmit active
// - two independent ports sharing clock and sync
// - received slot data goes to channel output
// - new rate used after second frame period
// - framing reference lags sync by programmed offset
// - reset floats transmit, clears all slot assignments
// - linear coding uses two adjacent slots
`timescale 1ns/1ps
module pcmh_highway_port
  import pcmh_pkg::*;
#(
  parameter int XFER_TICKS = CROSS_TICKS
)
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic BIT_CLK,
  input wire logic MODE_SELECT_HIGH,
  input wire logic MODE_SELECT_LOW,
  input wire logic FRAME_SYNC_INPUT,
  input wire logic RX_DATA_PORT_A,
  input wire logic RX_DATA_PORT_B,
  input wire logic [NCH*SLOT_W-1:0] TX_SLOT,
  input wire logic [NCH-1:0] TX_SLOT_EN,
  input wire logic [NCH*SLOT_W-1:0] RX_SLOT,
  input wire logic [NCH-1:0] RX_SLOT_EN,
  input wire logic [NCH-1:0] PORT_SEL_B,
  input wire logic LINEAR_MODE,
  input wire logic [OFS_W-1:0] TX_FRAME_OFFSET,
  input wire logic [OFS_W-1:0] RX_FRAME_OFFSET,
  input wire logic [TXS_W-1:0] TX_SAMPLE,
  output logic TX_DATA_PORT_A,
  output logic TX_DATA_OE_PORT_A,
  output logic TX_DATA_PORT_B,
  output logic TX_DATA_OE_PORT_B,
  output logic SLOT_STROBE_PORT_A,
  output logic SLOT_STROBE_OE_PORT_A,
  output logic SLOT_STROBE_PORT_B,
  output logic SLOT_STROBE_OE_PORT_B,
  output logic [TXS_W-1:0] RX_SAMPLE,
  output logic RX_SAMPLE_VALID,
  output logic RATE_LOCKED,
  output logic [1:0] RATE_CODE,
  output logic DEVICE_RUN
);
  localparam int TICK_W = $clog2(XFER_TICKS);

  logic [1:0] rst_pipe, lrst_pipe;
  logic core_rst_n, link_rst_n;
  logic [2:0][1:0] mode_pipe, next_mode_pipe;
  logic mode_run, next_mode_run, dev_run, next_dev_run;
  logic [TICK_W-1:0] tick_cnt, next_tick;
  pcmh_cfg_t cfg_now, link_cfg;
  logic [DOWN_W-1:0] down_data, down_q;
  logic [TXS_W-1:0] down_tx;
  logic [UP_W-1:0] up_q;
  logic sync_prev, next_sync_prev, frame_edge, frm_pulse;
  logic [FCNT_W-1:0] fcnt, next_fcnt;
  logic [NCH-1:0][SAMPLE_W-1:0] tx_frame, next_tx_frame;
  logic [NCH-1:0][SAMPLE_W-1:0] rx_shift, next_rx_shift, rx_word, next_rx_word;
  logic rx_last_any;
  logic [1:0] oe_q, txd_q, stb_oe_q, stb_lvl_q, next_oe, next_txd;

  pcmh_rate_if rif ();

  // position of a frame count inside a slot: {hit, bit index}
  function automatic logic [4:0] slot_hit(input logic [FCNT_W-1:0] cnt, input logic [OFS_W-1:0] ofs,
                                          input logic [SLOT_W-1:0] slot, input logic lin,
                                          input logic [7:0] slots);
    logic [FCNT_W-1:0] pos;
    logic [FCNT_W-1:0] base;
    logic [FCNT_W-1:0] d;
    begin
      pos = cnt - {8'h00, ofs};
      base = {1'b0, slot, 3'h0};
      d = pos - base;
      slot_hit = {(cnt >= {8'h00, ofs}) && (pos >= base) && (d < (lin ? LIN_BITS : BYTE_BITS))
                  && (pos[FCNT_W-1:3] < slots), d[3:0]};
    end
  endfunction : slot_hit

  // reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign core_rst_n = rst_pipe[1];

  // mode pins are asynchronous; any pattern but run holds the device in reset
  always_comb
  begin
    next_mode_pipe = {mode_pipe[1], mode_pipe[0], {MODE_SELECT_HIGH, MODE_SELECT_LOW}};
    next_mode_run = (mode_pipe[1] == mode_pipe[2]) ? (mode_pipe[2] == MODE_NORMAL) : mode_run;
    next_dev_run = mode_run;
    next_tick = (tick_cnt == TICK_W'(XFER_TICKS - 1)) ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge CORE_CLK or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      mode_pipe <= {3{MODE_RESET}};
      mode_run <= 1'b0;
      dev_run <= 1'b0;
      tick_cnt <= '0;
    end
    else
    begin
      mode_pipe <= next_mode_pipe;
      mode_run <= next_mode_run;
      dev_run <= next_dev_run;
      tick_cnt <= next_tick;
    end
  end

  // settings bundle; cleared while not running so no slot stays assigned
  always_comb
  begin
    cfg_now = CFG_RESET;
    for (int c = 0; c < NCH; c++)
    begin
      cfg_now.ch[c].tx_en = TX_SLOT_EN[c];
      cfg_now.ch[c].tx_slot = TX_SLOT[c*SLOT_W +: SLOT_W];
      cfg_now.ch[c].rx_en = RX_SLOT_EN[c];
      cfg_now.ch[c].rx_slot = RX_SLOT[c*SLOT_W +: SLOT_W];
      cfg_now.ch[c].port_b = PORT_SEL_B[c];
    end
    cfg_now.lin = LINEAR_MODE;
    cfg_now.tx_ofs = TX_FRAME_OFFSET;
    cfg_now.rx_ofs = RX_FRAME_OFFSET;
  end
  assign down_data = dev_run ? {cfg_now, TX_SAMPLE} : '0;

  // link reset follows the run state, released on the bit clock
  always_ff @(posedge BIT_CLK or negedge dev_run)
  begin
    if (!dev_run)
      lrst_pipe <= 2'h0;
    else
      lrst_pipe <= {lrst_pipe[0], 1'b1};
  end
  assign link_rst_n = lrst_pipe[1];

  // settings and samples reach the link side as one word
  pcmh_xing #(.W(DOWN_W)) u_down (
    .src_clk(CORE_CLK),
    .src_rst_n(core_rst_n),
    .src_load(tick_cnt == '0),
    .src_data(down_data),
    .dst_clk(BIT_CLK),
    .dst_rst_n(link_rst_n),
    .dst_data(down_q),
    .dst_valid()
  );
  assign link_cfg = pcmh_cfg_t'(down_q[DOWN_W-1:TXS_W]);
  assign down_tx = down_q[TXS_W-1:0];

  pcmh_rate_det u_rate (
    .clk(BIT_CLK),
    .rst_n(link_rst_n),
    .rif(rif.det)
  );
  assign frame_edge = FRAME_SYNC_INPUT && !sync_prev;
  assign rif.frame_start = frame_edge;
  assign rif.fcnt = fcnt;

  // falling edge: frame reference, bit count and receive shifting
  always_comb
  begin
    logic [4:0] h;
    logic rbit;
    h = '0;
    rbit = 1'b0;
    rx_last_any = 1'b0;
    next_sync_prev = FRAME_SYNC_INPUT;
    next_fcnt = frame_edge ? '0 : ((fcnt == FCNT_MAX) ? fcnt : fcnt + 11'h001);
    next_tx_frame = frame_edge ? down_tx : tx_frame; // word stays fixed for a frame
    next_rx_shift = rx_shift;
    next_rx_word = rx_word;
    for (int c = 0; c < NCH; c++)
    begin
      h = slot_hit(fcnt, link_cfg.rx_ofs, link_cfg.ch[c].rx_slot, link_cfg.lin, rif.slots);
      rbit = link_cfg.ch[c].port_b ? RX_DATA_PORT_B : RX_DATA_PORT_A;
      if (rif.locked && link_cfg.ch[c].rx_en && h[4])
      begin
        next_rx_shift[c] = {rx_shift[c][SAMPLE_W-2:0], rbit};
        if (h[3:0] == (link_cfg.lin ? LIN_LAST : BYTE_LAST))
        begin
          rx_last_any = 1'b1;
          next_rx_word[c] = link_cfg.lin ? {rx_shift[c][SAMPLE_W-2:0], rbit}
                                         : {8'h00, rx_shift[c][6:0], rbit};
        end
      end
    end
  end

  always_ff @(negedge BIT_CLK or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      sync_prev <= 1'b1; // a sync already high at release is not a frame edge
      fcnt <= FCNT_MAX;
      frm_pulse <= 1'b0;
      tx_frame <= '0;
      rx_shift <= '0;
      rx_word <= '0;
    end
    else
    begin
      sync_prev <= next_sync_prev;
      fcnt <= next_fcnt;
      frm_pulse <= frame_edge;
      tx_frame <= next_tx_frame;
      rx_shift <= next_rx_shift;
      rx_word <= next_rx_word;
    end
  end

  // rising edge: pick the lowest channel owning the slot on each port
  always_comb
  begin
    logic [4:0] h;
    h = '0;
    next_oe = 2'h0;
    next_txd = 2'h0;
    for (int p = 0; p < 2; p++)
    begin
      for (int c = NCH - 1; c >= 0; c--)
      begin
        h = slot_hit(fcnt, link_cfg.tx_ofs, link_cfg.ch[c].tx_slot, link_cfg.lin, rif.slots);
        if (rif.locked && link_cfg.ch[c].tx_en && link_cfg.ch[c].port_b == 1'(p) && h[4])
        begin
          next_oe[p] = 1'b1;
          next_txd[p] = link_cfg.lin ? tx_frame[c][LIN_LAST - h[3:0]] : tx_frame[c][BYTE_LAST - h[3:0]];
        end
      end
    end
  end

  always_ff @(posedge BIT_CLK or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      oe_q <= 2'h0;
      txd_q <= 2'h0;
      stb_oe_q <= 2'h0;
      stb_lvl_q <= 2'h3;
    end
    else
    begin
      oe_q <= next_oe;
      txd_q <= next_txd;
      stb_oe_q <= next_oe;
      stb_lvl_q <= ~next_oe;
    end
  end

  // received words and rate status go back once per frame
  pcmh_xing #(.W(UP_W)) u_up (
    .src_clk(BIT_CLK),
    .src_rst_n(link_rst_n),
    .src_load(frm_pulse),
    .src_data({rif.locked, rif.rate, rx_word}),
    .dst_clk(CORE_CLK),
    .dst_rst_n(core_rst_n),
    .dst_data(up_q),
    .dst_valid(RX_SAMPLE_VALID)
  );

  // received words straight from the crossing flops
  assign RX_SAMPLE = up_q[TXS_W-1:0];
  assign RATE_CODE = up_q[TXS_W+1:TXS_W];
  assign RATE_LOCKED = up_q[UP_W-1];
  assign DEVICE_RUN = dev_run;
  assign TX_DATA_PORT_A = txd_q[0];
  assign TX_DATA_OE_PORT_A = oe_q[0];
  assign TX_DATA_PORT_B = txd_q[1];
  assign TX_DATA_OE_PORT_B = oe_q[1];
  assign SLOT_STROBE_PORT_A = stb_lvl_q[0];
  assign SLOT_STROBE_OE_PORT_A = stb_oe_q[0];
  assign SLOT_STROBE_PORT_B = stb_lvl_q[1];
  assign SLOT_STROBE_OE_PORT_B = stb_oe_q[1];

  sequence s_frame_edge;
    FRAME_SYNC_INPUT && !sync_prev;
  endsequence

  sequence s_count_step;
    !(FRAME_SYNC_INPUT && !sync_prev) && fcnt != FCNT_MAX;
  endsequence

  a_reset_floats_tx:
  assert property (@(posedge BIT_CLK) !link_rst_n |-> oe_q == 2'h0 && stb_oe_q == 2'h0)
  else $error("transmit driven during reset");

  a_tx_after_lock:
  assert property (@(posedge BIT_CLK) disable iff (!link_rst_n) (|oe_q) |-> $past(rif.locked))
  else $error("transmit before rate lock");

  a_strobe_with_tx:
  assert property (@(posedge BIT_CLK) disable iff (!link_rst_n)
    stb_oe_q == oe_q && (stb_lvl_q & oe_q) == 2'h0)
  else $error("slot strobe not pulling low with transmit");

  a_frame_restart:
  assert property (@(negedge BIT_CLK) disable iff (!link_rst_n)
    s_frame_edge |=> (fcnt == '0 && frm_pulse) ##1 frm_pulse == 1'b0)
  else $error("frame count not restarted at sync edge");

  a_count_step:
  assert property (@(negedge BIT_CLK) disable iff (!link_rst_n) s_count_step |=> fcnt == $past(fcnt) + 11'h001)
  else $error("bit count did not advance by one");

  a_lock_on_frame:
  assert property (@(negedge BIT_CLK) disable iff (!link_rst_n) $rose(rif.locked) |-> $past(frame_edge))
  else $error("rate lock outside a frame edge");

  a_tx_past_offset:
  assert property (@(posedge BIT_CLK) disable iff (!link_rst_n)
    (|oe_q) |-> $past(fcnt) >= {8'h00, $past(link_cfg.tx_ofs)})
  else $error("transmit before the framing reference");

  a_rx_only_in_slot:
  assert property (@(negedge BIT_CLK) disable iff (!link_rst_n) ##1 $changed(rx_word) |-> $past(rx_last_any))
  else $error("receive word changed outside a slot");
endmodule : pcmh_highway_port

// >>> core/pcmh_pkg.sv
// pcmh_pkg: constants, types and encodings for the pcm highway port
// assumes: shared by the top, the rate detector and the word crossing
package pcmh_pkg;
  localparam int NCH = 4;
  localparam int SLOT_W = 7;
  localparam int OFS_W = 3;
  localparam int FCNT_W = 11;
  localparam int SAMPLE_W = 16;
  localparam int CROSS_TICKS = 256;
  localparam logic [FCNT_W-1:0] FCNT_MAX = 11'h7ff;
  localparam logic [FCNT_W-1:0] BYTE_BITS = 11'h008;
  localparam logic [FCNT_W-1:0] LIN_BITS = 11'h010;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] LIN_LAST = 4'hf;
  // mode pins as {high, low}
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  // frame lengths in bit clocks, read as count + 1 at the frame edge
  localparam logic [FCNT_W-1:0] PER_1M536 = 11'h0c0;
  localparam logic [FCNT_W-1:0] PER_1M544 = 11'h0c1;
  localparam logic [FCNT_W-1:0] PER_2M048 = 11'h100;
  localparam logic [FCNT_W-1:0] PER_4M096 = 11'h200;
  localparam logic [FCNT_W-1:0] PER_8M192 = 11'h400;
  localparam logic [7:0] SLOTS_1M5 = 8'h18;
  localparam logic [7:0] SLOTS_2M = 8'h20;
  localparam logic [7:0] SLOTS_4M = 8'h40;
  localparam logic [7:0] SLOTS_8M = 8'h80;

  typedef enum logic [1:0] {RATE_1M5 = 2'h0, RATE_2M = 2'h1, RATE_4M = 2'h3, RATE_8M = 2'h2} pcmh_rate_t;
  typedef enum logic [1:0] {RD_IDLE = 2'h0, RD_FIRST = 2'h1, RD_CHECK = 2'h3, RD_LOCK = 2'h2} pcmh_rd_state_t;

  typedef struct packed {
    logic tx_en;
    logic [SLOT_W-1:0] tx_slot;
    logic rx_en;
    logic [SLOT_W-1:0] rx_slot;
    logic port_b;
  } pcmh_chcfg_t;

  typedef struct packed {
    pcmh_chcfg_t [NCH-1:0] ch;
    logic lin;
    logic [OFS_W-1:0] tx_ofs;
    logic [OFS_W-1:0] rx_ofs;
  } pcmh_cfg_t;

  localparam int CFG_W = $bits(pcmh_cfg_t);
  localparam int TXS_W = NCH * SAMPLE_W;
  localparam int DOWN_W = CFG_W + TXS_W;
  localparam int UP_W = 3 + TXS_W;
  localparam pcmh_cfg_t CFG_RESET = '0;
endpackage : pcmh_pkg

// >>> core/pcmh_rate_det.sv
// pcmh_rate_det: finds the bit clock rate from the frame length
// assumes: clocked on the falling bit clock edge, fcnt restarts per frame
`timescale 1ns/1ps
module pcmh_rate_det
  import pcmh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  pcmh_rate_if.det rif
);
  pcmh_rd_state_t state, next_state;
  pcmh_rate_t cand, next_cand;
  logic [7:0] slots_q, next_slots;
  logic [2:0] cls;

  // frame length to {valid, rate}; 192 and 193 share one class
  function automatic logic [2:0] classify(input logic [FCNT_W-1:0] cnt);
    logic [FCNT_W-1:0] per;
    begin
      per = cnt + 11'h001;
      case (per)
        PER_1M536, PER_1M544: classify = {1'b1, RATE_1M5};
        PER_2M048: classify = {1'b1, RATE_2M};
        PER_4M096: classify = {1'b1, RATE_4M};
        PER_8M192: classify = {1'b1, RATE_8M};
        default: classify = 3'h0;
      endcase
    end
  endfunction : classify

  function automatic logic [7:0] slots_of(input pcmh_rate_t r);
    case (r)
      RATE_1M5: slots_of = SLOTS_1M5;
      RATE_2M: slots_of = SLOTS_2M;
      RATE_4M: slots_of = SLOTS_4M;
      default: slots_of = SLOTS_8M;
    endcase
  endfunction : slots_of

  // one full period to guess, a second matching one to commit
  always_comb
  begin
    cls = classify(rif.fcnt);
    next_state = state;
    next_cand = cand;
    next_slots = slots_q;
    if (rif.frame_start)
    begin
      case (state)
        RD_IDLE: next_state = RD_FIRST;
        RD_FIRST:
        begin
          if (cls[2])
          begin
            next_cand = pcmh_rate_t'(cls[1:0]);
            next_state = RD_CHECK;
          end
        end
        RD_CHECK:
        begin
          if (cls[2] && cls[1:0] == cand)
          begin
            next_state = RD_LOCK;
            next_slots = slots_of(cand);
          end
          else if (cls[2])
            next_cand = pcmh_rate_t'(cls[1:0]);
          else
            next_state = RD_FIRST;
        end
        RD_LOCK:
        begin
          if (!(cls[2] && cls[1:0] == cand))
            next_state = RD_FIRST; // rate lost, relearn
        end
        default: next_state = RD_IDLE;
      endcase
    end
  end

  always_ff @(negedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= RD_IDLE;
      cand <= RATE_1M5;
      slots_q <= '0;
    end
    else
    begin
      state <= next_state;
      cand <= next_cand;
      slots_q <= next_slots;
    end
  end

  assign rif.locked = (state == RD_LOCK);
  assign rif.rate = cand;
  assign rif.slots = slots_q;

  a_lock_after_check:
  assert property (@(negedge clk) disable iff (!rst_n)
    $rose(state == RD_LOCK) |-> $past(state) == RD_CHECK && $past(rif.frame_start))
  else $error("rate lock taken without a second matching period");
endmodule : pcmh_rate_det

// >>> core/pcmh_rate_if.sv
// pcmh_rate_if: frame edge and rate result between top and rate detector
// assumes: all members live on the falling edge of the bit clock
`timescale 1ns/1ps
interface pcmh_rate_if;
  import pcmh_pkg::*;
  logic frame_start;
  logic [FCNT_W-1:0] fcnt;
  logic locked;
  pcmh_rate_t rate;
  logic [7:0] slots;
  modport det (input frame_start, input fcnt, output locked, output rate, output slots);
  modport user (output frame_start, output fcnt, input locked, input rate, input slots);
endinterface : pcmh_rate_if

// >>> core/pcmh_xing.sv
// pcmh_xing: toggle handshake carrying one word between two clocks
// assumes: src_load pulses are spaced wider than four destination clocks
`timescale 1ns/1ps
module pcmh_xing
  import pcmh_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_load,
  input wire logic [W-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic [W-1:0] dst_data,
  output logic dst_valid
);
  logic [W-1:0] hold, next_hold, next_dst_data;
  logic tgl, next_tgl, seen, next_seen, next_dst_valid;
  logic [2:0] sy, next_sy;

  // source: hold stays still until the next load
  always_comb
  begin
    next_hold = src_load ? src_data : hold;
    next_tgl = src_load ? ~tgl : tgl;
  end

  always_ff @(posedge src_clk or negedge src_rst_n)
  begin
    if (!src_rst_n)
    begin
      hold <= '0;
      tgl <= 1'b0;
    end
    else
    begin
      hold <= next_hold;
      tgl <= next_tgl;
    end
  end

  // destination: toggle counts once second and third stage agree
  always_comb
  begin
    next_sy = {sy[1:0], tgl};
    next_dst_valid = (sy[1] == sy[2]) && (sy[2] != seen);
    next_seen = (sy[1] == sy[2]) ? sy[2] : seen;
    next_dst_data = next_dst_valid ? hold : dst_data;
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n)
  begin
    if (!dst_rst_n)
    begin
      sy <= '0;
      seen <= 1'b0;
      dst_valid <= 1'b0;
      dst_data <= '0;
    end
    else
    begin
      sy <= next_sy;
      seen <= next_seen;
      dst_valid <= next_dst_valid;
      dst_data <= next_dst_data;
    end
  end
endmodule : pcmh_xing

// >>> dv/pcm_highway_port_tb.sv
// pcm_highway_port_tb: self-checking bench for the highway port
// assumes: pcmh_far_model supplies bit clock, sync and rx data
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module pcm_highway_port_tb;
  import pcmh_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic BIT_CLK, FRAME_SYNC_INPUT, RX_DATA_PORT_A, RX_DATA_PORT_B;
  logic MODE_SELECT_HIGH = 1'b1;
  logic MODE_SELECT_LOW = 1'b0;
  logic [NCH*SLOT_W-1:0] TX_SLOT = '0;
  logic [NCH*SLOT_W-1:0] RX_SLOT = '0;
  logic [NCH-1:0] TX_SLOT_EN = 4'h1;
  logic [NCH-1:0] RX_SLOT_EN = 4'h0;
  logic [NCH-1:0] PORT_SEL_B = 4'h0;
  logic LINEAR_MODE = 1'b0;
  logic [OFS_W-1:0] TX_FRAME_OFFSET = 3'h0;
  logic [OFS_W-1:0] RX_FRAME_OFFSET = 3'h0;
  logic [TXS_W-1:0] TX_SAMPLE = 64'h0000_5671_34a9_12c5;
  logic TX_DATA_PORT_A, TX_DATA_OE_PORT_A, TX_DATA_PORT_B, TX_DATA_OE_PORT_B;
  logic SLOT_STROBE_PORT_A, SLOT_STROBE_OE_PORT_A, SLOT_STROBE_PORT_B, SLOT_STROBE_OE_PORT_B;
  logic [TXS_W-1:0] RX_SAMPLE;
  logic RX_SAMPLE_VALID, RATE_LOCKED, DEVICE_RUN;
  logic [1:0] RATE_CODE;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int vcnt = 0;
  logic watch = 1'b0;
  logic early = 1'b0;

  pcmh_highway_port #(.XFER_TICKS(160)) i_dut (.*);
  pcmh_far_model i_far (.*);

  // core clock, 50 MHz
  always #10 CORE_CLK = ~CORE_CLK;

  // flags any drive before the rate can have been learnt
  always @(posedge BIT_CLK)
    if (watch && (TX_DATA_OE_PORT_A || TX_DATA_OE_PORT_B))
      early <= 1'b1;

  // hang guard, well above the expected run length
  always @(posedge CORE_CLK)
  begin
    cyc <= cyc + 1;
    if (RX_SAMPLE_VALID)
      vcnt <= vcnt + 1; // one update pulse per frame
    if (cyc == 80000)
    begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  function automatic logic [1023:0] put(input logic [1023:0] v, input int st, input int n, input logic [15:0] w);
    for (int i = 0; i < n; i++)
      v[st + i] = w[n - 1 - i];
    return v;
  endfunction : put

  task automatic frames(input int n);
    repeat (n) @(posedge FRAME_SYNC_INPUT);
    @(posedge CORE_CLK);
  endtask : frames

  task automatic cmp_port(input int p, input logic [1023:0] eo, input logic [1023:0] ed);
    `CHK("tx_oe", eo, i_far.cap_oe[p])
    `CHK("tx_data", ed, i_far.cap_d[p] & eo)
    `CHK("strobe", eo, i_far.cap_st[p])
  endtask : cmp_port

  task automatic t_reset_lock;
    int n;
    repeat (4) @(posedge CORE_CLK);
    `CHK("oe_rst", 1'b0, TX_DATA_OE_PORT_A | TX_DATA_OE_PORT_B | SLOT_STROBE_OE_PORT_A)
    `CHK("st_rst", 1'b1, SLOT_STROBE_PORT_A & SLOT_STROBE_PORT_B)
    repeat (4) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    for (n = 0; n < 60 && DEVICE_RUN !== 1'b1; n++)
      @(posedge CORE_CLK);
    `CHK("run", 1'b1, DEVICE_RUN)
    watch <= 1'b1;
    frames(2);
    `CHK("early_oe", 1'b0, early)
    `CHK("lock_early", 1'b0, RATE_LOCKED)
    watch <= 1'b0;
    frames(3);
    `CHK("locked", 1'b1, RATE_LOCKED)
    `CHK("rate", RATE_2M, RATE_CODE)
  endtask : t_reset_lock

  // slot 0 on port A (plus slot 31 at offset 0 in byte mode), slot 5 on port B, shifted by the offset
  task automatic tx_case(input int ofs, input logic lin);
    int n;
    logic [15:0] m;
    logic [1023:0] ea, eb, oa, ob;
    n = lin ? 16 : 8;
    m = lin ? 16'hffff : 16'h00ff;
    @(posedge CORE_CLK);
    TX_FRAME_OFFSET <= 3'(ofs);
    LINEAR_MODE <= lin;
    TX_SLOT <= {7'h00, 7'h1f, 7'h05, 7'h00};
    TX_SLOT_EN <= (ofs == 0 && !lin) ? 4'h7 : 4'h3;
    PORT_SEL_B <= 4'h2;
    frames(4);
    oa = put('0, ofs, n, m);
    ea = put('0, ofs, n, 16'h12c5 & m);
    ob = put('0, 40 + ofs, n, m);
    eb = put('0, 40 + ofs, n, 16'h34a9 & m);
    if (ofs == 0 && !lin)
    begin
      oa = put(oa, 248, 8, m);
      ea = put(ea, 248, 8, 16'h0071);
    end
    cmp_port(0, oa, ea);
    cmp_port(1, ob, eb);
  endtask : tx_case

  // same slot 3 on both ports must give independent bytes
  task automatic t_rx;
    int v0;
    @(posedge CORE_CLK);
    i_far.rx_img[0] <= put({512{2'b01}}, 25, 8, 16'h00a7);
    i_far.rx_img[1] <= put({512{2'b01}}, 57, 8, 16'h003c);
    RX_FRAME_OFFSET <= 3'h1;
    LINEAR_MODE <= 1'b0;
    RX_SLOT <= {7'h07, 7'h00, 7'h03, 7'h03};
    RX_SLOT_EN <= 4'hb;
    PORT_SEL_B <= 4'ha;
    frames(4);
    `CHK("rx0", 16'h00a7, RX_SAMPLE[15:0])
    `CHK("rx1", 16'h0055, RX_SAMPLE[31:16])
    `CHK("rx3", 16'h003c, RX_SAMPLE[63:48])
    v0 = vcnt;
    frames(1);
    `CHK("valid_cnt", 1, vcnt - v0)
    // linear: each word spans its slot and the next one
    LINEAR_MODE <= 1'b1;
    frames(4);
    `CHK("rx0_lin", 16'ha755, RX_SAMPLE[15:0])
    `CHK("rx1_lin", 16'h5555, RX_SAMPLE[31:16])
    `CHK("rx3_lin", 16'h3c55, RX_SAMPLE[63:48])
  endtask : t_rx

  task automatic t_mode;
    logic [1:0] pat [3] = '{2'h0, 2'h1, 2'h3};
    foreach (pat[i])
    begin
      @(posedge CORE_CLK);
      {MODE_SELECT_HIGH, MODE_SELECT_LOW} <= pat[i];
      repeat (20) @(posedge CORE_CLK);
      `CHK("run_off", 1'b0, DEVICE_RUN)
      `CHK("oe_off", 1'b0, TX_DATA_OE_PORT_A | SLOT_STROBE_OE_PORT_A)
    end
    {MODE_SELECT_HIGH, MODE_SELECT_LOW} <= 2'h2;
    frames(3);
    `CHK("relearn", 1'b0, RATE_LOCKED)
    frames(3);
    `CHK("run_on", 1'b1, DEVICE_RUN)
    `CHK("relock", 1'b1, RATE_LOCKED)
  endtask : t_mode

  // each documented frame length, relearnt after every change
  task automatic t_rates;
    int len [5] = '{192, 193, 512, 1024, 256};
    pcmh_rate_t code [5] = '{RATE_1M5, RATE_1M5, RATE_4M, RATE_8M, RATE_2M};
    foreach (len[i])
    begin
      @(posedge CORE_CLK);
      i_far.frame_bits <= len[i];
      frames(5);
      `CHK("rate_code", code[i], RATE_CODE)
      `CHK("rate_lock", 1'b1, RATE_LOCKED)
    end
  endtask : t_rates

  // main sequence
  initial
  begin
    t_reset_lock();
    tx_case(0, 1'b0);
    tx_case(7, 1'b0);
    tx_case(1, 1'b1);
    t_rx();
    t_mode();
    t_rates();
    tally_and_finish();
  end
endmodule : pcm_highway_port_tb

// >>> dv/pcmh_far_model.sv
// pcmh_far_model: highway backplane, free bit clock, frame sync, rx data
// assumes: bench sets frame_bits and rx_img by hierarchy, reads cap_* arrays
`timescale 1ns/1ps
module pcmh_far_model
(
  output logic BIT_CLK,
  output logic FRAME_SYNC_INPUT,
  output logic RX_DATA_PORT_A,
  output logic RX_DATA_PORT_B,
  input wire logic TX_DATA_PORT_A,
  input wire logic TX_DATA_OE_PORT_A,
  input wire logic TX_DATA_PORT_B,
  input wire logic TX_DATA_OE_PORT_B,
  input wire logic SLOT_STROBE_PORT_A,
  input wire logic SLOT_STROBE_OE_PORT_A,
  input wire logic SLOT_STROBE_PORT_B,
  input wire logic SLOT_STROBE_OE_PORT_B
);
  int frame_bits = 256;
  int pos = 0;
  int nxt;
  int idx;
  int bi;
  logic [1023:0] rx_img [2];
  logic [1023:0] cap_oe [2];
  logic [1023:0] cap_d [2];
  logic [1023:0] cap_st [2];

  // 48 ns bit clock, free running as the highway master clock
  initial
  begin
    BIT_CLK = 1'b0;
    FRAME_SYNC_INPUT = 1'b0;
    RX_DATA_PORT_A = 1'b0;
    RX_DATA_PORT_B = 1'b0;
    rx_img = '{{512{2'b01}}, {512{2'b01}}};
    cap_oe = '{'0, '0};
    cap_d = '{'0, '0};
    cap_st = '{'0, '0};
    #7;
    forever #24 BIT_CLK = ~BIT_CLK;
  end

  // frame bit index of the bit launched by the last rising edge
  assign bi = (pos == 0) ? frame_bits - 1 : pos - 1;

  // one-bit sync per frame; unassigned rx bits toggle so stale values show
  always @(posedge BIT_CLK)
  begin
    nxt = (pos + 1 >= frame_bits) ? 0 : pos + 1;
    idx = (nxt == 0) ? frame_bits - 1 : nxt - 1;
    pos <= nxt;
    FRAME_SYNC_INPUT <= (nxt == 0);
    RX_DATA_PORT_A <= rx_img[0][idx];
    RX_DATA_PORT_B <= rx_img[1][idx];
  end

  // capture every position each frame so old slots are overwritten
  always @(negedge BIT_CLK)
  begin
    cap_oe[0][bi] <= TX_DATA_OE_PORT_A;
    cap_d[0][bi] <= TX_DATA_PORT_A;
    cap_st[0][bi] <= SLOT_STROBE_OE_PORT_A & ~SLOT_STROBE_PORT_A;
    cap_oe[1][bi] <= TX_DATA_OE_PORT_B;
    cap_d[1][bi] <= TX_DATA_PORT_B;
    cap_st[1][bi] <= SLOT_STROBE_OE_PORT_B & ~SLOT_STROBE_PORT_B;
  end
endmodule : pcmh_far_model
